// file: ditau_pkg.sv
// package: constants and carrier types of the dual input trigger angle unit
package ditau_pkg;

  // ---------------------------------------------------------------
  // register map (word offsets on the plain register port)
  // ---------------------------------------------------------------
  localparam logic [3:0] ADDR_CTRL     = 4'h0;
  localparam logic [3:0] ADDR_REV_LEN  = 4'h1;
  localparam logic [3:0] ADDR_DELAY    = 4'h2;
  localparam logic [3:0] ADDR_STATUS   = 4'h3;
  localparam logic [3:0] ADDR_ANGLE    = 4'h4;
  localparam logic [3:0] ADDR_STARTS   = 4'h5;

  // ---------------------------------------------------------------
  // control field layout
  // ---------------------------------------------------------------
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_GATE_BIT = 2;

  // ---------------------------------------------------------------
  // widths, limits and reset values
  // ---------------------------------------------------------------
  localparam int ANGLE_W = 15;
  localparam int DELAY_W = 16;
  localparam logic [14:0] REV_LEN_MIN   = 15'h0002;
  localparam logic [14:0] REV_LEN_MAX   = 15'h7FFF;
  localparam logic [14:0] REV_LEN_RESET = 15'h0168;
  localparam logic [15:0] DELAY_RESET   = 16'h0000;

  typedef enum logic [1:0] {
    MODE_OFF,
    MODE_EDGE,
    MODE_WINDOW,
    MODE_ANGLE
  } ditau_mode_t;

  // edge events of one synchronised trigger input
  typedef struct packed {
    logic level;
    logic rise;
    logic fall;
  } ditau_edge_t;

  // start indications toward the channel logic
  typedef struct packed {
    logic start_pulse;
    logic window_active;
    logic rev_wrap;
  } ditau_start_t;

endpackage : ditau_pkg

// file: ditau_edge_sync.sv
// two-stage synchroniser with edge detection for one trigger pin
`timescale 1ns/100ps
`default_nettype none

module ditau_edge_sync (
  // clock and reset
  input  wire logic            i_mclk,
  input  wire logic            i_rst,
  // pin and events
  input  wire logic            i_pin,
  output ditau_pkg::ditau_edge_t o_edge
);

  logic meta_ff;
  logic sync_ff;
  logic last_ff;
  logic nxt_meta;
  logic nxt_sync;
  logic nxt_last;

  always_comb begin
    nxt_meta = i_pin;
    nxt_sync = meta_ff;
    nxt_last = sync_ff;
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      last_ff <= 1'b0;
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
      last_ff <= nxt_last;
    end
  end

  // edges seen only after the second stage
  assign o_edge.level = sync_ff;
  assign o_edge.rise  = sync_ff & ~last_ff;
  assign o_edge.fall  = ~sync_ff & last_ff;

endmodule : ditau_edge_sync

`default_nettype wire

// file: ditau_trigger_unit.sv
// trigger unit: mode control, gating, window delay and angle counter
`timescale 1ns/100ps
`default_nettype none

module ditau_trigger_unit #(
  parameter int ANGLE_W = ditau_pkg::ANGLE_W,
  parameter int DELAY_W = ditau_pkg::DELAY_W
) (
  // clock and reset
  input  wire logic               i_mclk,
  input  wire logic               i_rst,
  // trigger pins
  input  wire logic               i_trig_one,
  input  wire logic               i_trig_two,
  // register port
  input  wire logic [3:0]         i_addr,
  input  wire logic [31:0]        i_wdata,
  input  wire logic               i_wr,
  input  wire logic               i_rd,
  output logic [31:0]             o_rdata,
  // channel side
  output ditau_pkg::ditau_start_t o_start,
  output logic [ANGLE_W-1:0]      o_angle
);

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  // pins are asynchronous: every event lags its pin by two clocks
  ditau_pkg::ditau_edge_t ev_one;
  ditau_pkg::ditau_edge_t ev_two;

  ditau_edge_sync u_sync_one (
    .i_mclk (i_mclk),
    .i_rst  (i_rst),
    .i_pin  (i_trig_one),
    .o_edge (ev_one)
  );

  ditau_edge_sync u_sync_two (
    .i_mclk (i_mclk),
    .i_rst  (i_rst),
    .i_pin  (i_trig_two),
    .o_edge (ev_two)
  );

  // ---------------------------------------------------------------
  // mode decode helpers
  // ---------------------------------------------------------------
  // off mode freezes the gate bit as the new mode, and as the old mode unless angle mode is written
  function automatic logic mode_is_off(input ditau_pkg::ditau_mode_t mode);
    return mode == ditau_pkg::MODE_OFF;
  endfunction

  // only edge and window mode can use input two as a gate
  function automatic logic mode_takes_gate(input ditau_pkg::ditau_mode_t mode);
    return mode == ditau_pkg::MODE_EDGE || mode == ditau_pkg::MODE_WINDOW;
  endfunction

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  // writes land at the next edge; a read in the same cycle sees the old value
  ditau_pkg::ditau_mode_t trigger_start_mode_select_ff;
  ditau_pkg::ditau_mode_t nxt_trigger_start_mode_select;
  logic                   second_input_gating_enable_ff;
  logic                   nxt_second_input_gating_enable;
  logic [ANGLE_W-1:0]     rev_len_ff;
  logic [ANGLE_W-1:0]     nxt_rev_len;
  logic [DELAY_W-1:0]     delay_ff;
  logic [DELAY_W-1:0]     nxt_delay;
  logic [ANGLE_W-1:0]     wr_len;
  ditau_pkg::ditau_mode_t wr_mode;

  always_comb begin
    nxt_trigger_start_mode_select  = trigger_start_mode_select_ff;
    nxt_second_input_gating_enable = second_input_gating_enable_ff;
    nxt_rev_len                    = rev_len_ff;
    nxt_delay                      = delay_ff;
    wr_mode = ditau_pkg::ditau_mode_t'(i_wdata[ditau_pkg::CTRL_MODE_LSB +: 2]);
    wr_len  = i_wdata[ANGLE_W-1:0];
    if (i_wr) begin
      unique case (i_addr)
        ditau_pkg::ADDR_CTRL: begin
          nxt_trigger_start_mode_select = wr_mode;
          if (wr_mode == ditau_pkg::MODE_ANGLE) begin
            nxt_second_input_gating_enable = 1'b1;
          end else if (!mode_is_off(trigger_start_mode_select_ff) &&
                       mode_takes_gate(wr_mode)) begin
            nxt_second_input_gating_enable = i_wdata[ditau_pkg::CTRL_GATE_BIT];
          end
        end
        ditau_pkg::ADDR_REV_LEN: begin
          // clamp to legal range
          // a length of one would wrap on every tooth
          if (wr_len < ANGLE_W'(ditau_pkg::REV_LEN_MIN)) begin
            nxt_rev_len = ANGLE_W'(ditau_pkg::REV_LEN_MIN);
          end else begin
            nxt_rev_len = wr_len;
          end
        end
        ditau_pkg::ADDR_DELAY: begin
          nxt_delay = i_wdata[DELAY_W-1:0];
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      trigger_start_mode_select_ff  <= ditau_pkg::MODE_OFF;
      second_input_gating_enable_ff <= 1'b0;
      rev_len_ff                    <= ditau_pkg::REV_LEN_RESET;
      delay_ff                      <= ditau_pkg::DELAY_RESET;
    end else begin
      trigger_start_mode_select_ff  <= nxt_trigger_start_mode_select;
      second_input_gating_enable_ff <= nxt_second_input_gating_enable;
      rev_len_ff                    <= nxt_rev_len;
      delay_ff                      <= nxt_delay;
    end
  end

  // ---------------------------------------------------------------
  // trigger engine
  // ---------------------------------------------------------------
  logic               gate_ok;
  logic               qual_rise;
  logic               start_ff;
  logic               nxt_start;
  logic               win_ff;
  logic               nxt_win;
  logic               win_wait_ff;
  logic               nxt_win_wait;
  logic [DELAY_W-1:0] dly_cnt_ff;
  logic [DELAY_W-1:0] nxt_dly_cnt;
  logic [ANGLE_W-1:0] angle_ff;
  logic [ANGLE_W-1:0] nxt_angle;
  logic               wrap_ff;
  logic               nxt_wrap;
  logic [31:0]        starts_ff;
  logic [31:0]        nxt_starts;

  // gate level is the synced pin, so it lags exactly like the edges
  // gate needs input-two high
  assign gate_ok   = ~second_input_gating_enable_ff | ev_two.level;
  assign qual_rise = ev_one.rise & gate_ok;

  always_comb begin
    nxt_start    = 1'b0;
    nxt_win      = win_ff;
    nxt_win_wait = win_wait_ff;
    nxt_dly_cnt  = dly_cnt_ff;
    nxt_angle    = angle_ff;
    nxt_wrap     = 1'b0;
    unique case (trigger_start_mode_select_ff)
      ditau_pkg::MODE_OFF: begin
        nxt_win      = 1'b0;
        nxt_win_wait = 1'b0;
      end
      ditau_pkg::MODE_EDGE: begin
        nxt_win      = 1'b0;
        nxt_win_wait = 1'b0;
        nxt_start    = qual_rise;
      end
      ditau_pkg::MODE_WINDOW: begin
        // gate qualifies the opening rise only; a close is never gated
        // fall closes window
        if (ev_one.fall) begin
          nxt_win      = 1'b0;
          nxt_win_wait = 1'b0;
        end else if (qual_rise) begin
          if (delay_ff == '0) begin
            nxt_win   = 1'b1;
            nxt_start = 1'b1;
          end else begin
            nxt_win_wait = 1'b1;
            // count down from the programmed delay, in clock cycles
            nxt_dly_cnt  = delay_ff;
          end
        end else if (win_wait_ff) begin
          if (dly_cnt_ff == DELAY_W'(1)) begin
            nxt_win_wait = 1'b0;
            nxt_win      = 1'b1;
            nxt_start    = 1'b1;
          end else begin
            nxt_dly_cnt = dly_cnt_ff - DELAY_W'(1);
          end
        end
      end
      ditau_pkg::MODE_ANGLE: begin
        nxt_win      = 1'b0;
        nxt_win_wait = 1'b0;
        // zero mark wins over a tooth fall in the same cycle
        // zero mark clears counter
        if (ev_one.rise) begin
          nxt_angle = '0;
        end else if (ev_two.fall) begin
          if (angle_ff >= rev_len_ff - ANGLE_W'(1)) begin
            nxt_angle = '0;
            nxt_wrap  = 1'b1;
          end else begin
            nxt_angle = angle_ff + ANGLE_W'(1);
          end
        end
      end
    endcase
    // start count wraps silently at its full width
    nxt_starts = starts_ff + {31'h0, nxt_start};
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      start_ff    <= 1'b0;
      win_ff      <= 1'b0;
      win_wait_ff <= 1'b0;
      dly_cnt_ff  <= '0;
      angle_ff    <= '0;
      wrap_ff     <= 1'b0;
      starts_ff   <= 32'h0;
    end else begin
      start_ff    <= nxt_start;
      win_ff      <= nxt_win;
      win_wait_ff <= nxt_win_wait;
      dly_cnt_ff  <= nxt_dly_cnt;
      angle_ff    <= nxt_angle;
      wrap_ff     <= nxt_wrap;
      starts_ff   <= nxt_starts;
    end
  end

  // every channel-side output comes straight from a flip-flop
  // counter is angular position
  assign o_angle               = angle_ff;
  assign o_start.start_pulse   = start_ff;
  assign o_start.window_active = win_ff;
  assign o_start.rev_wrap      = wrap_ff;

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  // read data stand one cycle only and read zero otherwise
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;

  always_comb begin
    nxt_rdata = 32'h0;
    if (i_rd) begin
      unique case (i_addr)
        ditau_pkg::ADDR_CTRL: begin
          nxt_rdata[ditau_pkg::CTRL_MODE_LSB +: 2] = trigger_start_mode_select_ff;
          nxt_rdata[ditau_pkg::CTRL_GATE_BIT]      = second_input_gating_enable_ff;
        end
        ditau_pkg::ADDR_REV_LEN: nxt_rdata[ANGLE_W-1:0] = rev_len_ff;
        ditau_pkg::ADDR_DELAY:   nxt_rdata[DELAY_W-1:0] = delay_ff;
        // status: synced pin levels, delay pending, window open
        ditau_pkg::ADDR_STATUS:  nxt_rdata[3:0] = {ev_two.level, ev_one.level,
                                                   win_wait_ff, win_ff};
        ditau_pkg::ADDR_ANGLE:   nxt_rdata[ANGLE_W-1:0] = angle_ff;
        ditau_pkg::ADDR_STARTS:  nxt_rdata = starts_ff;
        default:                 nxt_rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      rdata_ff <= 32'h0;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign o_rdata = rdata_ff;

endmodule : ditau_trigger_unit

`default_nettype wire

// file: ditau_trigger_unit_chk.sv
// checker: port-level properties of the trigger unit
`timescale 1ns/100ps
`default_nettype none
module ditau_trigger_unit_chk #(
  parameter int ANGLE_W = 15,
  parameter int DELAY_W = 16
) (
  // watched ports
  input wire logic                    i_mclk,
  input wire logic                    i_rst,
  input wire logic                    i_trig_one,
  input wire logic                    i_trig_two,
  input wire logic [3:0]              i_addr,
  input wire logic [31:0]             i_wdata,
  input wire logic                    i_wr,
  input wire logic                    i_rd,
  input wire logic [31:0]             o_rdata,
  input wire ditau_pkg::ditau_start_t o_start,
  input wire logic [ANGLE_W-1:0]      o_angle
);
  // ----
  // mode shadow, written mode only
  // ----
  logic [1:0] mode_ff;
  logic [1:0] nxt_mode;
  always_comb begin
    nxt_mode = mode_ff;
    if (i_wr && i_addr == ditau_pkg::ADDR_CTRL)
      nxt_mode = i_wdata[1:0];
  end
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst)
      mode_ff <= 2'h0;
    else
      mode_ff <= nxt_mode;
  end
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_rst);
  a_off_no_start: assert property (mode_ff == 2'h0 && $past(mode_ff) == 2'h0
    |-> !o_start.start_pulse) else $error("start in off mode");
  a_edge_gate_start: assert property ($rose(i_trig_one) && mode_ff == 2'h1
    && i_trig_two |-> ##[2:5] o_start.start_pulse) else $error("edge start missing");
  a_window_close: assert property ($fell(i_trig_one) && o_start.window_active
    |-> ##[1:5] !o_start.window_active) else $error("window not closed");
  a_window_mode: assert property (o_start.window_active
    |-> mode_ff == 2'h2 || $past(mode_ff) == 2'h2) else $error("window outside window mode");
  a_angle_clear: assert property ($rose(i_trig_one) && mode_ff == 2'h3
    |-> ##[2:5] o_angle == '0) else $error("angle not cleared");
  a_angle_step: assert property ($changed(o_angle)
    |-> o_angle == $past(o_angle) + 1'b1 || o_angle == '0) else $error("angle jump");
  a_wrap_zero: assert property (o_start.rev_wrap |-> o_angle == '0
    ##1 !o_start.rev_wrap) else $error("wrap pulse wrong");
  a_angle_read: assert property (i_rd && i_addr == ditau_pkg::ADDR_ANGLE
    |=> o_rdata[ANGLE_W-1:0] == $past(o_angle)) else $error("angle read wrong");
  a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 32'h0)
    else $error("read data not idle");
  c_start: cover property (o_start.start_pulse);
  c_window: cover property (o_start.window_active);
  c_wrap: cover property (o_start.rev_wrap);
endmodule // ditau_trigger_unit_chk
bind ditau_trigger_unit ditau_trigger_unit_chk #(.ANGLE_W(ANGLE_W), .DELAY_W(DELAY_W)) chk_inst (
  .i_mclk(i_mclk), .i_rst(i_rst), .i_trig_one(i_trig_one), .i_trig_two(i_trig_two),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
  .o_rdata(o_rdata), .o_start(o_start), .o_angle(o_angle));
`default_nettype wire

// file: ditau_trig_src.sv
// partner: trigger pulse sources, zero mark and tooth wheel
`timescale 1ns/100ps
`default_nettype none
module ditau_trig_src (
  // clock
  input wire logic  i_mclk,
  // pins toward the unit
  output logic      o_trig_one,
  output logic      o_trig_two
);
  initial begin
    o_trig_one = 1'b0;
    o_trig_two = 1'b0;
  end
  // zero mark falls in tooth gap
  task automatic pulse_one(input int h);
    @(posedge i_mclk);
    o_trig_one <= 1'b1;
    repeat (h) @(posedge i_mclk);
    o_trig_one <= 1'b0;
    // low time lets the sync chain settle
    repeat (6) @(posedge i_mclk);
  endtask
  task automatic set_two(input logic v);
    @(posedge i_mclk);
    o_trig_two <= v;
    repeat (6) @(posedge i_mclk);
  endtask
  task automatic teeth(input int n);
    repeat (n) begin
      @(posedge i_mclk);
      o_trig_two <= 1'b1;
      repeat (3) @(posedge i_mclk);
      o_trig_two <= 1'b0;
      repeat (2) @(posedge i_mclk);
    end
    repeat (6) @(posedge i_mclk);
  endtask
endmodule // ditau_trig_src
`default_nettype wire

// file: ditau_trigger_unit_tb.sv
// testbench: register and trigger scenarios for the trigger unit
`timescale 1ns/100ps
`default_nettype none
module ditau_trigger_unit_tb;
  logic                          i_mclk = 1'b0;
  logic                          i_rst = 1'b1;
  logic [3:0]                    i_addr = 4'h0;
  logic [31:0]                   i_wdata = 32'h0;
  logic                          i_wr = 1'b0;
  logic                          i_rd = 1'b0;
  logic                          rd_d = 1'b0;
  logic                          trig_one;
  logic                          trig_two;
  logic [31:0]                   o_rdata;
  ditau_pkg::ditau_start_t       o_start;
  logic [ditau_pkg::ANGLE_W-1:0] o_angle;
  logic [31:0]                   exp_q[$];
  int                            bad_count = 0;
  int                            cmp_count = 0;
  integer                        seed = 32'h5B324139;
  int                            k;
  int                            dly;
  int                            r;
  int                            start_seen = 0;
  int                            wrap_seen = 0;
  int                            win_seen = 0;
  logic                          win_d = 1'b0;
  always #2 i_mclk = ~i_mclk;
  ditau_trigger_unit ditau_trigger_unit_inst (.i_mclk(i_mclk), .i_rst(i_rst),
    .i_trig_one(trig_one), .i_trig_two(trig_two), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_start(o_start), .o_angle(o_angle));
  ditau_trig_src ditau_trig_src_inst (.i_mclk(i_mclk), .o_trig_one(trig_one),
    .o_trig_two(trig_two));
  // ----
  // bus tasks and result watcher
  // ----
  task automatic cmp(input logic [31:0] got, input logic [31:0] e);
    cmp_count++;
    if (got !== e) begin
      $display("mismatch t=%0t got %h exp %h", $time, got, e);
      bad_count++;
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_mclk);
    i_wr <= 1'b0;
    // idle bus carries noise that the unit must ignore
    i_addr <= 4'($random(seed));
    i_wdata <= $random(seed);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge i_mclk);
    i_addr <= a;
    i_rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge i_mclk);
    i_rd <= 1'b0;
    i_addr <= 4'($random(seed));
    i_wdata <= $random(seed);
  endtask
  always @(posedge i_mclk) begin
    if (rd_d)
      cmp(o_rdata, exp_q.pop_front());
    rd_d <= i_rd;
  end
  // port watcher: pulses and window openings seen on the channel side
  always @(posedge i_mclk) begin
    if (o_start.start_pulse === 1'b1)
      start_seen++;
    if (o_start.rev_wrap === 1'b1)
      wrap_seen++;
    if (o_start.window_active === 1'b1 && win_d === 1'b0)
      win_seen++;
    win_d <= o_start.window_active;
  end
  task automatic tally_and_finish();
    repeat (4) @(posedge i_mclk);
    $display("errors %0d in %0d compares", bad_count, cmp_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    #200000;
    bad_count++;
    tally_and_finish();
  end
  initial begin
    repeat (16) @(posedge i_mclk);
    i_rst <= 1'b0;
    rd(ditau_pkg::ADDR_CTRL, 32'h0);
    rd(ditau_pkg::ADDR_REV_LEN, 32'h168);
    rd(4'hF, 32'h0);
    ditau_trig_src_inst.pulse_one(3);
    rd(ditau_pkg::ADDR_STARTS, 32'h0);
    wr(ditau_pkg::ADDR_CTRL, 32'h4);
    rd(ditau_pkg::ADDR_CTRL, 32'h0);
    wr(ditau_pkg::ADDR_CTRL, 32'h1);
    for (int n = 0; n < 3; n++)
      ditau_trig_src_inst.pulse_one(2 + $unsigned($random(seed)) % 6);
    rd(ditau_pkg::ADDR_STARTS, 32'h3);
    wr(ditau_pkg::ADDR_CTRL, 32'h5);
    rd(ditau_pkg::ADDR_CTRL, 32'h5);
    ditau_trig_src_inst.pulse_one(3);
    ditau_trig_src_inst.set_two(1'b1);
    ditau_trig_src_inst.pulse_one(3);
    ditau_trig_src_inst.set_two(1'b0);
    rd(ditau_pkg::ADDR_STARTS, 32'h4);
    wr(ditau_pkg::ADDR_CTRL, 32'h2);
    dly = 8 + $unsigned($random(seed)) % 16;
    wr(ditau_pkg::ADDR_DELAY, 32'(dly));
    rd(ditau_pkg::ADDR_DELAY, 32'(dly));
    ditau_trig_src_inst.pulse_one(4);
    rd(ditau_pkg::ADDR_STARTS, 32'h4);
    ditau_trig_src_inst.pulse_one(30);
    rd(ditau_pkg::ADDR_STARTS, 32'h5);
    wr(ditau_pkg::ADDR_REV_LEN, 32'h1);
    rd(ditau_pkg::ADDR_REV_LEN, 32'h2);
    wr(ditau_pkg::ADDR_REV_LEN, 32'h7FFF);
    rd(ditau_pkg::ADDR_REV_LEN, 32'h7FFF);
    r = 5 + $unsigned($random(seed)) % 4;
    wr(ditau_pkg::ADDR_REV_LEN, 32'(r));
    wr(ditau_pkg::ADDR_CTRL, 32'h3);
    rd(ditau_pkg::ADDR_CTRL, 32'h7);
    ditau_trig_src_inst.pulse_one(2);
    k = 1 + $unsigned($random(seed)) % 4;
    ditau_trig_src_inst.teeth(k);
    rd(ditau_pkg::ADDR_ANGLE, 32'(k));
    cmp(32'(o_angle), 32'(k));
    ditau_trig_src_inst.teeth(7);
    rd(ditau_pkg::ADDR_ANGLE, 32'((k + 7) % r));
    ditau_trig_src_inst.pulse_one(2);
    rd(ditau_pkg::ADDR_ANGLE, 32'h0);
    // mid-run reset with a nonzero angle
    ditau_trig_src_inst.teeth(2);
    @(posedge i_mclk);
    i_rst <= 1'b1;
    repeat (3) @(posedge i_mclk);
    i_rst <= 1'b0;
    rd(ditau_pkg::ADDR_ANGLE, 32'h0);
    rd(ditau_pkg::ADDR_CTRL, 32'h0);
    rd(ditau_pkg::ADDR_DELAY, 32'h0);
    rd(ditau_pkg::ADDR_REV_LEN, 32'(ditau_pkg::REV_LEN_RESET));
    ditau_trig_src_inst.pulse_one(3);
    rd(ditau_pkg::ADDR_STARTS, 32'h0);
    cmp(32'(start_seen), 32'h5);
    cmp(32'(win_seen), 32'h1);
    cmp(32'(wrap_seen), 32'((k + 7) / r));
    tally_and_finish();
  end
endmodule // ditau_trigger_unit_tb
`default_nettype wire
